// [rtl/pcarf_params.svh]
// Constants of the counter array run and flag control block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef PCARF_PARAMS_SVH
`define PCARF_PARAMS_SVH

// Register offsets
`define PCARF_ADDR_CTRL 8'h00
`define PCARF_ADDR_MASK 8'h01
`define PCARF_ADDR_CNT_LO 8'h02
`define PCARF_ADDR_CNT_HI 8'h03
`define PCARF_ADDR_PEND 8'h04

// Field positions in the control, mask and pending layout
`define PCARF_BIT_OVF 7
`define PCARF_BIT_RUN 6
`define PCARF_BIT_MOD_TOP 5

// Reset values and unmapped read data
`define PCARF_CTRL_RESET 8'h00
`define PCARF_MASK_RESET 8'h00
`define PCARF_COUNT_RESET 16'h0000
`define PCARF_RDATA_RESET 8'h00
`define PCARF_UNMAPPED_READ 8'h00

// Counter limit
`define PCARF_COUNT_MAX 16'hFFFF

`endif

// [rtl/pcarf_pkg.sv]
// Types of the counter array run and flag control block.
// Assumes the params header is compiled alongside.
package pcarf_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pcarf_bus_req_type;

	typedef struct packed {
		logic overflow;
		logic run;
		logic [5:0] module_flags;
	} pcarf_ctrl_type;

	typedef struct packed {
		logic load_lo;
		logic load_hi;
		logic [7:0] data;
	} pcarf_cnt_load_type;

endpackage : pcarf_pkg

// [rtl/pcarf_flag_bank.sv]
// Bank of sticky event flags, set by hardware, cleared by software.
// Assumes set and clear vectors synchronous to the clock.
`timescale 1ns/100ps
module pcarf_flag_bank #(
	parameter int WIDTH = 7
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Set and clear requests
	input wire logic [WIDTH-1:0] set_in,
	input wire logic [WIDTH-1:0] clr_in,
	// Flag state
	output logic [WIDTH-1:0] flags_out
);

	logic [WIDTH-1:0] flags_r;
	logic [WIDTH-1:0] flags_nxt;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			// Set beats clear so a coincident event is not lost
			assign flags_nxt[i] = set_in[i] | (flags_r[i] & ~clr_in[i]);
		end
	endgenerate

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			flags_r <= '0;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	assign flags_out = flags_r;

endmodule : pcarf_flag_bank

// [rtl/pcarf_counter.sv]
// Shared 16-bit counter/timer with run gate, byte loads and wrap pulse.
// Assumes one tick input from the array timebase.
`timescale 1ns/100ps
module pcarf_counter #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic resetn_in,
	// Control
	input wire logic run_in,
	input wire logic tick_in,
	input wire pcarf_pkg::pcarf_cnt_load_type load_in,
	// State
	output logic [WIDTH-1:0] count_out,
	output logic wrap_out
);
`include "pcarf_params.svh"

	logic [WIDTH-1:0] count_r;
	logic [WIDTH-1:0] count_nxt;
	wire advance = run_in & tick_in;
	wire at_max = (count_r == WIDTH'(`PCARF_COUNT_MAX));
	wire loading = load_in.load_lo | load_in.load_hi;

	// Software load wins over counting; the loaded byte would be stale otherwise
	always_comb begin
		count_nxt = count_r;
		if (load_in.load_lo) begin
			count_nxt[7:0] = load_in.data;
		end else if (load_in.load_hi) begin
			count_nxt[WIDTH-1:8] = load_in.data[WIDTH-9:0];
		end else if (advance) begin
			count_nxt = count_r + WIDTH'(1);
		end
	end

	// Wrap seen as a one-cycle pulse on the advance past the maximum
	assign wrap_out = advance & at_max & ~loading;

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			count_r <= WIDTH'(`PCARF_COUNT_RESET);
		end else begin
			count_r <= count_nxt;
		end
	end

	assign count_out = count_r;

endmodule : pcarf_counter

// [rtl/pcarf_top.sv]
// Run control and flag register of a programmable counter array.
// Assumes a plain register port and event pulses synchronous to REF_CLK_IN.
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps
module pcarf_top #(
	parameter int NUM_MODULES = 6,
	parameter int COUNT_WIDTH = 16
) (
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RESETN_IN,
	// Register port
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	output logic [7:0] REG_RDATA_OUT,
	// Counter timebase and module events
	input wire logic COUNT_TICK_IN,
	input wire logic [NUM_MODULES-1:0] MODULE_EVENT_IN,
	// Counter state to the capture/compare modules
	output logic [COUNT_WIDTH-1:0] COUNT_OUT,
	output logic COUNT_RUN_OUT,
	output logic COUNT_WRAP_OUT,
	// Interrupt
	output logic IRQ_OUT
);
`include "pcarf_params.svh"

	localparam int FLAG_WIDTH = NUM_MODULES + 1;
	// Named so the run bit's reset value can be picked out by position
	localparam logic [7:0] CTRL_RESET = `PCARF_CTRL_RESET;

	// Bus request carried as one struct
	pcarf_pkg::pcarf_bus_req_type bus_req;
	assign bus_req.addr = REG_ADDR_IN;
	assign bus_req.wdata = REG_WDATA_IN;
	assign bus_req.wr = REG_WR_IN;
	assign bus_req.rd = REG_RD_IN;

	// Address decode
	wire sel_ctrl = (bus_req.addr == `PCARF_ADDR_CTRL);
	wire sel_mask = (bus_req.addr == `PCARF_ADDR_MASK);
	wire sel_cnt_lo = (bus_req.addr == `PCARF_ADDR_CNT_LO);
	wire sel_cnt_hi = (bus_req.addr == `PCARF_ADDR_CNT_HI);
	wire sel_pend = (bus_req.addr == `PCARF_ADDR_PEND);
	wire sel_mapped = sel_ctrl | sel_mask | sel_cnt_lo | sel_cnt_hi | sel_pend;

	// Write strobes per register
	wire wr_ctrl = bus_req.wr & sel_ctrl;
	wire wr_mask = bus_req.wr & sel_mask;
	wire wr_cnt_lo = bus_req.wr & sel_cnt_lo;
	wire wr_cnt_hi = bus_req.wr & sel_cnt_hi;

	// Read strobes with side effects
	wire rd_cnt_lo = bus_req.rd & sel_cnt_lo;

	// Run-control bit, gating the counter together with the timebase tick
	logic run_r;
	logic run_nxt;
	assign run_nxt = wr_ctrl ? bus_req.wdata[`PCARF_BIT_RUN] : run_r;

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			run_r <= CTRL_RESET[`PCARF_BIT_RUN];
		end else begin
			run_r <= run_nxt;
		end
	end

	// Interrupt mask, same layout as control; run position reserved
	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	logic [7:0] mask_writable;

	always_comb begin
		mask_writable = 8'h00;
		mask_writable[`PCARF_BIT_OVF] = 1'b1;
		mask_writable[NUM_MODULES-1:0] = '1;
	end

	assign mask_nxt = wr_mask ? (bus_req.wdata & mask_writable) : mask_r;

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			mask_r <= `PCARF_MASK_RESET;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// Counter byte loads from software
	pcarf_pkg::pcarf_cnt_load_type cnt_load;
	assign cnt_load.load_lo = wr_cnt_lo;
	assign cnt_load.load_hi = wr_cnt_hi;
	assign cnt_load.data = bus_req.wdata;

	logic [COUNT_WIDTH-1:0] count;
	logic count_wrap;

	pcarf_counter #(
		.WIDTH(COUNT_WIDTH)
	) u_counter (
		.clk_in(REF_CLK_IN),
		.resetn_in(RESETN_IN),
		.run_in(run_r),
		.tick_in(COUNT_TICK_IN),
		.load_in(cnt_load),
		.count_out(count),
		.wrap_out(count_wrap)
	);

	// High byte snapshot on low byte read keeps a 16-bit read coherent
	logic [7:0] hi_shadow_r;
	logic [7:0] hi_shadow_nxt;
	assign hi_shadow_nxt = rd_cnt_lo ? count[COUNT_WIDTH-1:8] : hi_shadow_r;

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			hi_shadow_r <= 8'h00;
		end else begin
			hi_shadow_r <= hi_shadow_nxt;
		end
	end

	// Flag sets: top entry is the overflow, the rest are module events
	logic [FLAG_WIDTH-1:0] flag_set;
	logic [FLAG_WIDTH-1:0] flag_clr;
	logic [FLAG_WIDTH-1:0] flags;

	assign flag_set[NUM_MODULES] = count_wrap;
	assign flag_clr[NUM_MODULES] = wr_ctrl & bus_req.wdata[`PCARF_BIT_OVF];

	genvar m;
	generate
		for (m = 0; m < NUM_MODULES; m++) begin : g_module
			// Match or capture on module m, module 5 among them
			assign flag_set[m] = MODULE_EVENT_IN[m];
			// Only a software write of one clears; hardware has no clear path
			assign flag_clr[m] = wr_ctrl & bus_req.wdata[m];
		end
	endgenerate

	pcarf_flag_bank #(
		.WIDTH(FLAG_WIDTH)
	) u_flags (
		.clk_in(REF_CLK_IN),
		.resetn_in(RESETN_IN),
		.set_in(flag_set),
		.clr_in(flag_clr),
		.flags_out(flags)
	);

	// Control register image
	pcarf_pkg::pcarf_ctrl_type ctrl_view;

	always_comb begin
		ctrl_view = '0;
		ctrl_view.overflow = flags[NUM_MODULES];
		ctrl_view.run = run_r;
		ctrl_view.module_flags[NUM_MODULES-1:0] = flags[NUM_MODULES-1:0];
	end

	wire [7:0] ctrl_word = ctrl_view;

	// Pending interrupts: sticky flags gated by mask
	wire [7:0] pend_word = ctrl_word & mask_r;
	wire ovf_pending = pend_word[`PCARF_BIT_OVF];
	wire capcmp_pending = |pend_word[`PCARF_BIT_MOD_TOP:0];

	// Read mux
	logic [7:0] rdata_sel;

	always_comb begin
		rdata_sel = `PCARF_UNMAPPED_READ;
		if (sel_ctrl) begin
			rdata_sel = ctrl_word;
		end else if (sel_mask) begin
			rdata_sel = mask_r;
		end else if (sel_cnt_lo) begin
			rdata_sel = count[7:0];
		end else if (sel_cnt_hi) begin
			rdata_sel = hi_shadow_r;
		end else if (sel_pend) begin
			rdata_sel = pend_word;
		end
	end

	// Read data stands only in the cycle after the strobe
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	assign rdata_nxt = (bus_req.rd && sel_mapped) ? rdata_sel : `PCARF_RDATA_RESET;

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rdata_r <= `PCARF_RDATA_RESET;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// Registered interrupt level; one cycle of latency avoids a glitchy output
	logic irq_r;
	logic irq_nxt;
	assign irq_nxt = ovf_pending | capcmp_pending;

	always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// Outputs
	assign REG_RDATA_OUT = rdata_r;
	assign COUNT_OUT = count;
	assign COUNT_RUN_OUT = run_r;
	assign COUNT_WRAP_OUT = count_wrap;
	assign IRQ_OUT = irq_r;

endmodule : pcarf_top

// [verif/pcarf_chk.sv]
// Port assertions of the counter array run and flag control block.
// Assumes binding into pcarf_top, one clock, reset active low.
`timescale 1ns/100ps
module pcarf_chk #(
	parameter int NUM_MODULES = 6,
	parameter int COUNT_WIDTH = 16
) (
	// Clock and reset
	input wire logic REF_CLK_IN,
	input wire logic RESETN_IN,
	// Register port
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	// Counter, events, interrupt
	input wire logic COUNT_TICK_IN,
	input wire logic [NUM_MODULES-1:0] MODULE_EVENT_IN,
	input wire logic [COUNT_WIDTH-1:0] COUNT_OUT,
	input wire logic COUNT_RUN_OUT,
	input wire logic COUNT_WRAP_OUT,
	input wire logic IRQ_OUT
);
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RESETN_IN);
	// Writes excluded, since a byte load may move the count
	run_hold_a: assert property (!COUNT_RUN_OUT && !REG_WR_IN |=> $stable(COUNT_OUT))
		else $error("count moved while stopped");
	run_step_a: assert property (COUNT_RUN_OUT && COUNT_TICK_IN && !REG_WR_IN
		|=> COUNT_OUT == $past(COUNT_OUT) + 1'b1)
		else $error("count did not step");
	wrap_cause_a: assert property (COUNT_WRAP_OUT
		|-> COUNT_OUT == '1 && COUNT_RUN_OUT && COUNT_TICK_IN)
		else $error("wrap without cause");
	wrap_zero_a: assert property (COUNT_WRAP_OUT |=> COUNT_OUT == '0)
		else $error("count not zero after wrap");
	run_bit_a: assert property (REG_WR_IN && REG_ADDR_IN == 8'h00
		|=> COUNT_RUN_OUT == $past(REG_WDATA_IN[6]))
		else $error("run bit not written");
	mod5_flag_a: assert property (REG_RD_IN && REG_ADDR_IN == 8'h00
		&& $past(MODULE_EVENT_IN[5]) |=> REG_RDATA_OUT[5])
		else $error("module 5 flag not set");
	irq_cause_a: assert property ($rose(IRQ_OUT) |-> $past(MODULE_EVENT_IN, 2) != '0
		|| $past(COUNT_WRAP_OUT, 2) || ($past(REG_WR_IN, 2) && $past(REG_ADDR_IN, 2) == 8'h01))
		else $error("interrupt rose without cause");
	irq_clear_a: assert property ($fell(IRQ_OUT)
		|-> $past(REG_WR_IN, 2) && $past(REG_ADDR_IN, 2) <= 8'h01)
		else $error("interrupt fell without software write");
endmodule : pcarf_chk

bind pcarf_top pcarf_chk #(.NUM_MODULES(NUM_MODULES), .COUNT_WIDTH(COUNT_WIDTH)) pcarf_chk_inst (
	.REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .REG_ADDR_IN(REG_ADDR_IN),
	.REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT), .COUNT_TICK_IN(COUNT_TICK_IN),
	.MODULE_EVENT_IN(MODULE_EVENT_IN), .COUNT_OUT(COUNT_OUT), .COUNT_RUN_OUT(COUNT_RUN_OUT),
	.COUNT_WRAP_OUT(COUNT_WRAP_OUT), .IRQ_OUT(IRQ_OUT));

// [verif/tb.sv]
// Self-checking bench of the counter array run and flag control block.
// Assumes pcarf_top with default parameters and a 10 MHz clock.
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tick = 1'b1;
	logic [5:0] events = 6'h00;
	logic [7:0] rdata;
	logic [15:0] count;
	logic run;
	logic irq;
	logic wrap;
	int n_wrap = 0;
	int n_fail = 0;
	int checks = 0;
	int cycles = 0;

	pcarf_top pcarf_top_inst (
		.REF_CLK_IN(clk), .RESETN_IN(resetn), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .COUNT_TICK_IN(tick),
		.MODULE_EVENT_IN(events), .COUNT_OUT(count), .COUNT_RUN_OUT(run),
		.COUNT_WRAP_OUT(wrap), .IRQ_OUT(irq));

	initial begin
		forever #50 clk = ~clk;
	end

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Read data exist only in the cycle after the strobe
	task rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk({8'h00, rdata}, {8'h00, exp});
	endtask : rd_chk

	task end_of_test;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	// Run needs some 110 cycles
	always @(posedge clk) begin
		cycles++;
		if (wrap) begin
			n_wrap++;
		end
		if (cycles == 3000) begin
			n_fail++;
			end_of_test();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		rd_chk(8'h00, 8'h00);
		rd_chk(8'h01, 8'h00);
		rd_chk(8'h04, 8'h00);
		rd_chk(8'h07, 8'h00);
		$display("test reset done");
		// Stopped counter keeps a loaded value
		wr_reg(8'h02, 8'hF0);
		wr_reg(8'h03, 8'hFF);
		repeat (5) @(posedge clk);
		rd_chk(8'h02, 8'hF0);
		rd_chk(8'h03, 8'hFF);
		chk(count, 16'hFFF0);
		$display("test hold done");
		wr_reg(8'h01, 8'h80);
		wr_reg(8'h00, 8'h40);
		#1;
		chk({15'h0000, run}, 16'h0001);
		repeat (30) @(posedge clk);
		rd_chk(8'h00, 8'hC0);
		chk({15'h0000, irq}, 16'h0001);
		chk(16'(n_wrap), 16'h0001);
		wr_reg(8'h00, 8'h80);
		repeat (2) @(posedge clk);
		#1;
		chk({15'h0000, irq}, 16'h0000);
		rd_chk(8'h00, 8'h00);
		$display("test overflow done");
		// All modules fire; only module 5 is unmasked
		wr_reg(8'h01, 8'h20);
		events <= 6'h3F;
		rd_chk(8'h00, 8'h3F);
		@(posedge clk);
		events <= 6'h00;
		repeat (20) @(posedge clk);
		rd_chk(8'h04, 8'h20);
		chk({15'h0000, irq}, 16'h0001);
		wr_reg(8'h00, 8'h00);
		rd_chk(8'h00, 8'h3F);
		wr_reg(8'h00, 8'h20);
		rd_chk(8'h00, 8'h1F);
		chk({15'h0000, irq}, 16'h0000);
		wr_reg(8'h01, 8'h01);
		repeat (2) @(posedge clk);
		#1;
		chk({15'h0000, irq}, 16'h0001);
		wr_reg(8'h00, 8'h1F);
		rd_chk(8'h00, 8'h00);
		$display("test flags done");
		// Run set but no timebase tick: count must hold
		@(posedge clk);
		tick <= 1'b0;
		wr_reg(8'h00, 8'h40);
		repeat (3) @(posedge clk);
		#1;
		chk(count, 16'h0012);
		chk({15'h0000, run}, 16'h0001);
		$display("test tick done");
		end_of_test();
	end
endmodule : tb
